// File: rtl/tlbl_cp_decode.sv
// tlbl_cp_decode: decodes coprocessor selectors into this block's registers and operations
// assumes: purely combinational, selectors stable while the transfer is offered
`timescale 1ns/1ps
`default_nettype none
module tlbl_cp_decode (
	// selectors
	input wire logic [2:0] opcode1,
	input wire logic [3:0] primaryRegisterNumber,
	input wire logic [3:0] secondaryRegisterNumber,
	input wire logic [2:0] thirdSelector,
	// decoded targets
	output logic selLockdown,
	output logic selPrimaryRemap,
	output logic selNormalRemap,
	output logic selInvalidate,
	output logic invShared,
	output tlbl_pkg::tlbl_inv_t invKind
);
	logic sys;
	logic sharedCrm;
	logic localCrm;

	always_comb begin
		sys = (opcode1 == tlbl_pkg::OP1_SYS);
		sharedCrm = (secondaryRegisterNumber == tlbl_pkg::CRM_INV_SHARED);
		localCrm = (secondaryRegisterNumber >= tlbl_pkg::CRM_INV_LOCAL_LO)
			&& (secondaryRegisterNumber <= tlbl_pkg::CRM_INV_LOCAL_HI);
		selLockdown = sys && (primaryRegisterNumber == tlbl_pkg::CRN_REGION)
			&& (secondaryRegisterNumber == tlbl_pkg::CRM_LOCKDOWN)
			&& (thirdSelector == tlbl_pkg::OP2_LOCKDOWN);
		selPrimaryRemap = sys && (primaryRegisterNumber == tlbl_pkg::CRN_REGION)
			&& (secondaryRegisterNumber == tlbl_pkg::CRM_REMAP)
			&& (thirdSelector == tlbl_pkg::OP2_PRIMARY_REMAP);
		selNormalRemap = sys && (primaryRegisterNumber == tlbl_pkg::CRN_REGION)
			&& (secondaryRegisterNumber == tlbl_pkg::CRM_REMAP)
			&& (thirdSelector == tlbl_pkg::OP2_NORMAL_REMAP);
		// third selector 4 to 7 is not an operation here
		selInvalidate = sys && (primaryRegisterNumber == tlbl_pkg::CRN_INVALIDATE)
			&& (sharedCrm || localCrm) && !thirdSelector[2];
		invShared = sharedCrm;
		invKind = tlbl_pkg::tlbl_inv_t'(thirdSelector[1:0]);
	end
endmodule // tlbl_cp_decode
`default_nettype wire

// File: rtl/tlbl_entry_bank.sv
// tlbl_entry_bank: a bank of translation entries with indexed refill, lookup and invalidate
// assumes: one refill and one invalidate per cycle; refill wins on the same entry
`timescale 1ns/1ps
`default_nettype none
module tlbl_entry_bank #(
	parameter int ENTRIES = 4,
	parameter int IDX_W = 2,
	parameter bit LOCKED = 1'b0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// refill
	input wire logic wrEn,
	input wire logic [IDX_W-1:0] wrIdx,
	input wire logic [tlbl_pkg::VA_W-1:0] wrVa,
	input wire logic [tlbl_pkg::ASID_W-1:0] wrAsid,
	input wire logic wrGlobal,
	input wire logic [tlbl_pkg::VA_W-1:0] wrPa,
	// invalidate
	input wire logic invEn,
	input wire tlbl_pkg::tlbl_inv_t invKind,
	input wire logic [tlbl_pkg::VA_W-1:0] invVa,
	input wire logic [tlbl_pkg::ASID_W-1:0] invAsid,
	// lookup
	input wire logic [tlbl_pkg::VA_W-1:0] lookVa,
	input wire logic [tlbl_pkg::ASID_W-1:0] lookAsid,
	output logic hit,
	output logic [tlbl_pkg::VA_W-1:0] hitPa,
	// state view
	output logic [ENTRIES-1:0] validVec,
	output logic [ENTRIES-1:0] invMatchVec
);
	logic [ENTRIES-1:0] valid_ff;
	logic [tlbl_pkg::VA_W-1:0] va_ff [ENTRIES];
	logic [tlbl_pkg::ASID_W-1:0] asid_ff [ENTRIES];
	logic [ENTRIES-1:0] global_ff;
	logic [tlbl_pkg::VA_W-1:0] pa_ff [ENTRIES];
	logic [ENTRIES-1:0] lookMatch;

	// a global entry answers every identifier
	function automatic logic addrMatch(input logic [tlbl_pkg::VA_W-1:0] ev,
		input logic [tlbl_pkg::ASID_W-1:0] ea, input logic eg,
		input logic [tlbl_pkg::VA_W-1:0] qv, input logic [tlbl_pkg::ASID_W-1:0] qa);
		addrMatch = (ev == qv) && (eg || (ea == qa));
	endfunction

	genvar g;
	generate
		for (g = 0; g < ENTRIES; g++) begin : gEntry
			always_comb begin
				lookMatch[g] = valid_ff[g]
					&& addrMatch(va_ff[g], asid_ff[g], global_ff[g], lookVa, lookAsid);
				unique case (invKind)
					tlbl_pkg::INV_ALL: invMatchVec[g] = !LOCKED;
					tlbl_pkg::INV_BY_ADDR: invMatchVec[g] = addrMatch(va_ff[g], asid_ff[g],
						global_ff[g], invVa, invAsid);
					tlbl_pkg::INV_BY_ID: invMatchVec[g] = !global_ff[g]
						&& (asid_ff[g] == invAsid);
					tlbl_pkg::INV_ADDR_ANY_ID: invMatchVec[g] = !LOCKED
						&& (va_ff[g] == invVa);
				endcase
			end

			always_ff @(posedge sys_clk) begin
				if (rst) begin
					valid_ff[g] <= 1'b0;
				end else if (wrEn && (wrIdx == IDX_W'(g))) begin
					valid_ff[g] <= 1'b1;
				end else if (invEn && invMatchVec[g]) begin
					valid_ff[g] <= 1'b0;
				end
			end

			always_ff @(posedge sys_clk) begin
				if (wrEn && (wrIdx == IDX_W'(g))) begin
					va_ff[g] <= wrVa;
					asid_ff[g] <= wrAsid;
					global_ff[g] <= wrGlobal;
					pa_ff[g] <= wrPa;
				end
			end
		end
	endgenerate

	always_comb begin
		hit = |lookMatch;
		hitPa = '0;
		for (int i = 0; i < ENTRIES; i++) begin
			if (lookMatch[i]) begin
				hitPa = hitPa | pa_ff[i];
			end
		end
		validVec = valid_ff;
	end
endmodule // tlbl_entry_bank
`default_nettype wire

// File: rtl/tlbl_lockdown_ctrl.sv
// tlbl_lockdown_ctrl: lockdown refill control, remap registers and tlb invalidate operations
// assumes: one coprocessor transfer offered per cycle, answered at the next edge;
// table walks and lookups come from the memory system on the same clock
`timescale 1ns/1ps
`default_nettype none
module tlbl_lockdown_ctrl #(
	parameter int SETS = 32,
	parameter int SET_W = 5
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// coprocessor transfer
	input wire logic cpValid,
	input wire logic cpWrite,
	input wire logic [2:0] cpOpcode1,
	input wire logic [3:0] cpPrimaryRegisterNumber,
	input wire logic [3:0] cpSecondaryRegisterNumber,
	input wire logic [2:0] cpThirdSelector,
	input wire logic [31:0] cpWdata,
	input wire logic cpPrivileged,
	input wire logic cpNonSecure,
	input wire logic nonsecureLockdownAccessBit,
	output logic cpDone_ff,
	output logic cpUndef_ff,
	output logic [31:0] cpRdata_ff,
	output logic invBroadcast_ff,
	// table walk refill
	input wire logic walkValid,
	input wire logic [tlbl_pkg::VA_W-1:0] walkVa,
	input wire logic [tlbl_pkg::ASID_W-1:0] walkAsid,
	input wire logic walkGlobal,
	input wire logic [tlbl_pkg::VA_W-1:0] walkPa,
	// lookup
	input wire logic lookValid,
	input wire logic [tlbl_pkg::VA_W-1:0] lookVa,
	input wire logic [tlbl_pkg::ASID_W-1:0] lookAsid,
	output logic lookHit_ff,
	output logic lookLocked_ff,
	output logic [tlbl_pkg::VA_W-1:0] lookPa_ff,
	// memory attribute remap
	output logic [31:0] primaryRegionRemap_ff,
	output logic [31:0] normalMemoryRemap_ff
);
	// ---------------------------------------------------------------
	// decode and access checks
	// ---------------------------------------------------------------
	logic selLockdown;
	logic selPrimaryRemap;
	logic selNormalRemap;
	logic selInvalidate;
	logic invShared;
	tlbl_pkg::tlbl_inv_t invKind;
	logic lockAllowed;
	logic accessOk;
	logic lockWrite;
	logic invAccept;
	logic [31:0] nxt_rdata;
	// slot select is two bits wide
	localparam int LOCK_SLOT_HI = tlbl_pkg::LOCK_SLOT_LSB + 1;

	tlbl_cp_decode uDecode (
		.opcode1(cpOpcode1),
		.primaryRegisterNumber(cpPrimaryRegisterNumber),
		.secondaryRegisterNumber(cpSecondaryRegisterNumber),
		.thirdSelector(cpThirdSelector),
		.selLockdown(selLockdown),
		.selPrimaryRemap(selPrimaryRemap),
		.selNormalRemap(selNormalRemap),
		.selInvalidate(selInvalidate),
		.invShared(invShared),
		.invKind(invKind)
	);

	logic preserve_ff;
	logic [1:0] slot_ff;
	logic way_ff;

	always_comb begin
		// one shared copy: the security state only gates access
		lockAllowed = !cpNonSecure || nonsecureLockdownAccessBit;
		accessOk = cpPrivileged && ((selLockdown && lockAllowed) || selPrimaryRemap
			|| selNormalRemap || (selInvalidate && cpWrite));
		lockWrite = cpValid && cpWrite && accessOk && selLockdown;
		invAccept = cpValid && accessOk && selInvalidate;
		nxt_rdata = '0;
		if (selLockdown) begin
			nxt_rdata[LOCK_SLOT_HI:tlbl_pkg::LOCK_SLOT_LSB] = slot_ff;
			nxt_rdata[tlbl_pkg::LOCK_PRESERVE_BIT] = preserve_ff;
		end else if (selPrimaryRemap) begin
			nxt_rdata = primaryRegionRemap_ff;
		end else if (selNormalRemap) begin
			nxt_rdata = normalMemoryRemap_ff;
		end
	end

	// ---------------------------------------------------------------
	// transfer answer
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cpDone_ff <= 1'b0;
			cpUndef_ff <= 1'b0;
			cpRdata_ff <= '0;
		end else begin
			cpDone_ff <= cpValid;
			cpUndef_ff <= cpValid && !accessOk;
			// refused or write transfers read back zero
			cpRdata_ff <= (cpValid && !cpWrite && accessOk) ? nxt_rdata : '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			invBroadcast_ff <= 1'b0;
		end else begin
			invBroadcast_ff <= invAccept && invShared;
		end
	end

	// ---------------------------------------------------------------
	// lockdown control and remap registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			preserve_ff <= tlbl_pkg::LOCKDOWN_RESET[tlbl_pkg::LOCK_PRESERVE_BIT];
			slot_ff <= tlbl_pkg::LOCKDOWN_RESET[LOCK_SLOT_HI:tlbl_pkg::LOCK_SLOT_LSB];
		end else if (lockWrite) begin
			preserve_ff <= cpWdata[tlbl_pkg::LOCK_PRESERVE_BIT];
			slot_ff <= cpWdata[LOCK_SLOT_HI:tlbl_pkg::LOCK_SLOT_LSB];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			primaryRegionRemap_ff <= tlbl_pkg::PRIMARY_REMAP_RESET;
			normalMemoryRemap_ff <= tlbl_pkg::NORMAL_REMAP_RESET;
		end else if (cpValid && cpWrite && accessOk) begin
			if (selPrimaryRemap) begin
				primaryRegionRemap_ff <= cpWdata;
			end
			if (selNormalRemap) begin
				normalMemoryRemap_ff <= cpWdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// refill steering
	// ---------------------------------------------------------------
	// a walk in the same cycle as a lockdown write still uses the old setting
	logic lockWrEn;
	logic mainWrEn;
	logic [SET_W:0] mainWrIdx;

	always_comb begin
		lockWrEn = walkValid && preserve_ff;
		mainWrEn = walkValid && !preserve_ff;
		mainWrIdx = {way_ff, walkVa[SET_W-1:0]};
	end

	// two ways, replaced alternately
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			way_ff <= 1'b0;
		end else if (mainWrEn) begin
			way_ff <= !way_ff;
		end
	end

	// ---------------------------------------------------------------
	// entry banks
	// ---------------------------------------------------------------
	logic lockHit;
	logic mainHit;
	logic [tlbl_pkg::VA_W-1:0] lockPa;
	logic [tlbl_pkg::VA_W-1:0] mainPa;
	logic [tlbl_pkg::LOCK_ENTRIES-1:0] lockValid;
	logic [tlbl_pkg::LOCK_ENTRIES-1:0] lockInvMatch;
	logic [tlbl_pkg::VA_W-1:0] opndVa;
	logic [tlbl_pkg::ASID_W-1:0] opndAsid;

	always_comb begin
		opndVa = cpWdata[31:tlbl_pkg::OPND_VA_LSB];
		opndAsid = cpWdata[tlbl_pkg::ASID_W-1:0];
	end

	tlbl_entry_bank #(
		.ENTRIES(tlbl_pkg::LOCK_ENTRIES),
		.IDX_W(2),
		.LOCKED(1'b1)
	) uLockBank (
		.sys_clk(sys_clk),
		.rst(rst),
		.wrEn(lockWrEn),
		.wrIdx(slot_ff),
		.wrVa(walkVa),
		.wrAsid(walkAsid),
		.wrGlobal(walkGlobal),
		.wrPa(walkPa),
		.invEn(invAccept),
		.invKind(invKind),
		.invVa(opndVa),
		.invAsid(opndAsid),
		.lookVa(lookVa),
		.lookAsid(lookAsid),
		.hit(lockHit),
		.hitPa(lockPa),
		.validVec(lockValid),
		.invMatchVec(lockInvMatch)
	);

	tlbl_entry_bank #(
		.ENTRIES(2 * SETS),
		.IDX_W(SET_W + 1),
		.LOCKED(1'b0)
	) uMainBank (
		.sys_clk(sys_clk),
		.rst(rst),
		.wrEn(mainWrEn),
		.wrIdx(mainWrIdx),
		.wrVa(walkVa),
		.wrAsid(walkAsid),
		.wrGlobal(walkGlobal),
		.wrPa(walkPa),
		.invEn(invAccept),
		.invKind(invKind),
		.invVa(opndVa),
		.invAsid(opndAsid),
		.lookVa(lookVa),
		.lookAsid(lookAsid),
		.hit(mainHit),
		.hitPa(mainPa),
		.validVec(),
		.invMatchVec()
	);

	// ---------------------------------------------------------------
	// lookup answer
	// ---------------------------------------------------------------
	// locked entry takes precedence if both regions hold the page
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lookHit_ff <= 1'b0;
			lookLocked_ff <= 1'b0;
			lookPa_ff <= '0;
		end else begin
			lookHit_ff <= lookValid && (lockHit || mainHit);
			lookLocked_ff <= lookValid && lockHit;
			lookPa_ff <= !lookValid ? '0 : (lockHit ? lockPa : mainPa);
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	lock_slot_fill_a: assert property (lockWrEn |=> lockValid[$past(slot_ff)])
		else $error("locked refill did not validate its slot");
	refill_lock_a: assert property (walkValid && preserve_ff |=> $stable(way_ff)
		&& lockValid[$past(slot_ff)])
		else $error("refill not steered to lockdown region");
	refill_main_a: assert property (walkValid && !preserve_ff |=>
		way_ff != $past(way_ff) && (lockValid & ~$past(lockValid)) == '0)
		else $error("refill not steered to set-associative region");
	lock_reset_a: assert property ($past(rst) |-> !preserve_ff && slot_ff == 2'h0)
		else $error("lockdown control not zero after reset");
	unpriv_refuse_a: assert property (cpValid && !cpPrivileged |=> cpUndef_ff && cpDone_ff)
		else $error("unprivileged transfer not refused");
	ns_block_a: assert property (cpValid && cpWrite && selLockdown && cpNonSecure
		&& !nonsecureLockdownAccessBit |=> cpUndef_ff && $stable(preserve_ff)
		&& $stable(slot_ff))
		else $error("non-secure lockdown write not blocked");
	inv_keep_lock_a: assert property (invAccept && !lockWrEn
		&& (invKind == tlbl_pkg::INV_ALL || invKind == tlbl_pkg::INV_ADDR_ANY_ID)
		|=> lockValid == $past(lockValid))
		else $error("invalidate touched a locked entry");
	inv_match_lock_a: assert property (invAccept && !lockWrEn
		&& (invKind == tlbl_pkg::INV_BY_ADDR || invKind == tlbl_pkg::INV_BY_ID)
		|=> (lockValid & $past(lockInvMatch)) == '0)
		else $error("matching locked entry survived invalidate");
	inv_read_undef_a: assert property (cpValid && !cpWrite && selInvalidate |=> cpUndef_ff)
		else $error("read of write-only invalidate not refused");
	lock_readback_a: assert property (lockWrite ##1 !lockWrite ##1
		(cpValid && !cpWrite && selLockdown && accessOk) |=> cpRdata_ff == {2'h0,
		$past(cpWdata[29:28], 3), 27'h0, $past(cpWdata[0], 3)})
		else $error("lockdown control readback wrong");
	remap_reset_a: assert property ($past(rst) |->
		primaryRegionRemap_ff == 32'h0009_8aa4 && normalMemoryRemap_ff == 32'h44e0_48e0)
		else $error("remap registers not at reset value");
	lookup_hit_a: assert property (lookValid && (lockHit || mainHit) |=> lookHit_ff)
		else $error("lookup hit not reported");

	// transfer answers stand for one cycle only
	done_pulse_a: assert property (cpValid
		|=> cpDone_ff)
		else $error("transfer not answered");
	idle_quiet_a: assert property (!cpValid
		|=> !cpDone_ff && !cpUndef_ff && cpRdata_ff == 32'h0)
		else $error("answer without transfer");
	op1_refuse_a: assert property (cpValid
		&& cpOpcode1 != 3'h0 |=> cpUndef_ff)
		else $error("foreign opcode accepted");
	write_rdata_a: assert property (cpValid && cpWrite
		|=> cpRdata_ff == 32'h0)
		else $error("write returned read data");
	ns_allow_a: assert property (cpValid && cpPrivileged && selLockdown
		&& cpNonSecure && nonsecureLockdownAccessBit |=> !cpUndef_ff)
		else $error("permitted non-secure access refused");
	secure_lock_a: assert property (cpValid && cpPrivileged
		&& selLockdown && !cpNonSecure |=> !cpUndef_ff)
		else $error("secure lockdown access refused");

	lock_write_a: assert property (lockWrite |=>
		preserve_ff == $past(cpWdata[0]) && slot_ff == $past(cpWdata[29:28]))
		else $error("lockdown write not taken");
	lock_hold_a: assert property (!lockWrite |=>
		$stable(preserve_ff) && $stable(slot_ff))
		else $error("lockdown control changed unasked");
	bcast_set_a: assert property (invAccept
		&& invShared |=> invBroadcast_ff)
		else $error("shared invalidate not broadcast");
	bcast_quiet_a: assert property (!(invAccept && invShared)
		|=> !invBroadcast_ff)
		else $error("broadcast without shared invalidate");

	// lookup answers
	look_idle_a: assert property (!lookValid |=>
		!lookHit_ff && !lookLocked_ff && lookPa_ff == '0)
		else $error("lookup answer without request");
	look_lock_a: assert property (lookValid && lockHit |=>
		lookLocked_ff && lookPa_ff == $past(lockPa))
		else $error("locked lookup answer wrong");

	lock_refill_c: cover property (lockWrEn ##1 lookValid && lockHit);
	inv_shared_c: cover property (invAccept && invShared);
	ns_allowed_c: cover property (lockWrite && cpNonSecure);
	main_hit_c: cover property (lookValid && mainHit && !lockHit);
	lock_readback_c: cover property (lockWrite ##2 (cpValid && !cpWrite && selLockdown));
endmodule // tlbl_lockdown_ctrl
`default_nettype wire

// File: rtl/tlbl_pkg.sv
// tlbl_pkg: constants and types for the tlb lockdown and invalidate control block
// assumes: coprocessor register selectors arrive decoded as opcode1, primary, secondary, third
//
// Notes on behaviour
// - besides the set-associative region there is a lockdown region of exactly four entries
// - preserve set: every later table walk refills lockdown slot chosen by slot select
// - preserve clear: every later table walk refills the set-associative region
// - after reset preserve is clear and the lockdown control register reads zero
// - lockdown control register is privileged only, one copy for both security states
// - non-secure access to lockdown control needs the non-secure lockdown access bit set
// - invalidate-all and address-for-all-identifiers leave every locked entry valid
// - invalidate by address or by identifier also removes a matching locked entry
// - write-only invalidates at primary 8; shared secondary 3, local 5 to 7
// - lockdown control register sits at primary 10, secondary 0, third selector 0
// - primary region remap register resets to 0x00098aa4
// - normal memory remap register resets to 0x44e048e0
package tlbl_pkg;
	// -----------------------------------------------------------------
	// register selectors
	// -----------------------------------------------------------------
	localparam logic [2:0] OP1_SYS = 3'h0;
	localparam logic [3:0] CRN_INVALIDATE = 4'h8;
	localparam logic [3:0] CRM_INV_SHARED = 4'h3;
	localparam logic [3:0] CRM_INV_LOCAL_LO = 4'h5;
	localparam logic [3:0] CRM_INV_LOCAL_HI = 4'h7;
	localparam logic [3:0] CRN_REGION = 4'ha;
	localparam logic [3:0] CRM_LOCKDOWN = 4'h0;
	localparam logic [2:0] OP2_LOCKDOWN = 3'h0;
	localparam logic [3:0] CRM_REMAP = 4'h2;
	localparam logic [2:0] OP2_PRIMARY_REMAP = 3'h0;
	localparam logic [2:0] OP2_NORMAL_REMAP = 3'h1;

	// -----------------------------------------------------------------
	// fields and reset values
	// -----------------------------------------------------------------
	localparam int LOCK_SLOT_LSB = 28;
	localparam int LOCK_PRESERVE_BIT = 0;
	localparam int LOCK_ENTRIES = 4;
	localparam logic [31:0] LOCKDOWN_RESET = 32'h0000_0000;
	localparam logic [31:0] PRIMARY_REMAP_RESET = 32'h0009_8aa4;
	localparam logic [31:0] NORMAL_REMAP_RESET = 32'h44e0_48e0;
	localparam int OPND_VA_LSB = 12;
	localparam int VA_W = 20;
	localparam int ASID_W = 8;

	typedef enum logic [1:0] {
		INV_ALL = 2'b00,
		INV_BY_ADDR = 2'b01,
		INV_BY_ID = 2'b10,
		INV_ADDR_ANY_ID = 2'b11
	} tlbl_inv_t;
endpackage

// File: testbench/tlbl_lockdown_ctrl_tb.sv
// tlbl_lockdown_ctrl_tb: self-checking bench for lockdown refill, remap and invalidate control
// assumes: tlbl_pkg compiled first; the bench drives every port of the block itself
`timescale 1ns/1ps
`default_nettype none
module tlbl_lockdown_ctrl_tb;
	typedef logic [tlbl_pkg::VA_W-1:0] tlbl_va_t;
	typedef logic [tlbl_pkg::ASID_W-1:0] tlbl_asid_t;

	// -----------------------------------------------------------------
	// stimulus and observed signals
	// -----------------------------------------------------------------
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cpValid = 1'b0, cpWrite = 1'b0, cpPrivileged = 1'b1, cpNonSecure = 1'b0;
	logic nonsecureLockdownAccessBit = 1'b0;
	logic [2:0] cpOpcode1 = 3'h0, cpThirdSelector = 3'h0;
	logic [3:0] cpPrimaryRegisterNumber = 4'h0, cpSecondaryRegisterNumber = 4'h0;
	logic [31:0] cpWdata = 32'h0, cpRdata_ff, primaryRegionRemap_ff, normalMemoryRemap_ff;
	logic cpDone_ff, cpUndef_ff, invBroadcast_ff, lookHit_ff, lookLocked_ff;
	logic walkValid = 1'b0, walkGlobal = 1'b0, lookValid = 1'b0;
	tlbl_va_t walkVa = '0, walkPa = '0, lookVa = '0, lookPa_ff;
	tlbl_asid_t walkAsid = '0, lookAsid = '0;
	// transfer context, applied by the cp task at its launching edge
	logic priv = 1'b1, nsec = 1'b0, nsAcc = 1'b0, ok;
	logic [2:0] op1 = 3'h0;
	logic [31:0] rnd = 32'hf7712e7a, d, cur;
	logic [3:0] secondary_register_number;
	tlbl_va_t baseVa, paA, paB, paC;
	tlbl_va_t lockVa [4];
	tlbl_va_t lockPa [4];
	int kind;
	int error_cnt = 0;
	int check_count = 0;

	always #2 sys_clk = ~sys_clk;

	tlbl_lockdown_ctrl #(.SETS(32), .SET_W(5)) i_dut (
		.sys_clk(sys_clk), .rst(rst), .cpValid(cpValid), .cpWrite(cpWrite),
		.cpOpcode1(cpOpcode1), .cpPrimaryRegisterNumber(cpPrimaryRegisterNumber),
		.cpSecondaryRegisterNumber(cpSecondaryRegisterNumber), .cpThirdSelector(cpThirdSelector),
		.cpWdata(cpWdata), .cpPrivileged(cpPrivileged), .cpNonSecure(cpNonSecure),
		.nonsecureLockdownAccessBit(nonsecureLockdownAccessBit), .cpDone_ff(cpDone_ff),
		.cpUndef_ff(cpUndef_ff), .cpRdata_ff(cpRdata_ff), .invBroadcast_ff(invBroadcast_ff),
		.walkValid(walkValid), .walkVa(walkVa), .walkAsid(walkAsid), .walkGlobal(walkGlobal),
		.walkPa(walkPa), .lookValid(lookValid), .lookVa(lookVa), .lookAsid(lookAsid),
		.lookHit_ff(lookHit_ff), .lookLocked_ff(lookLocked_ff), .lookPa_ff(lookPa_ff),
		.primaryRegionRemap_ff(primaryRegionRemap_ff), .normalMemoryRemap_ff(normalMemoryRemap_ff)
	);

	// -----------------------------------------------------------------
	// expectation helpers and bus tasks
	// -----------------------------------------------------------------
	function automatic logic [31:0] lfsrNext(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// only slot select and preserve are kept; the rest reads back zero
	function automatic logic [31:0] lockView(input logic [31:0] w);
		return {2'b00, w[29:28], 27'h0, w[0]};
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cp(input logic w, input logic [3:0] primary_register_number, input logic [3:0] sec,
			input logic [2:0] op2, input logic [31:0] wd, input logic eu, input logic [31:0] er);
		@(posedge sys_clk);
		cpValid <= 1'b1;
		cpWrite <= w;
		cpOpcode1 <= op1;
		cpPrimaryRegisterNumber <= primary_register_number;
		cpSecondaryRegisterNumber <= sec;
		cpThirdSelector <= op2;
		cpWdata <= wd;
		cpPrivileged <= priv;
		cpNonSecure <= nsec;
		nonsecureLockdownAccessBit <= nsAcc;
		@(posedge sys_clk);
		cpValid <= 1'b0;
		#1;
		check("cpDone", {31'h0, cpDone_ff}, 32'h1);
		check("cpUndef", {31'h0, cpUndef_ff}, {31'h0, eu});
		check("cpRdata", cpRdata_ff, er);
	endtask

	task automatic walk(input tlbl_va_t va, input tlbl_asid_t id, input logic g, input tlbl_va_t pa);
		@(posedge sys_clk);
		walkValid <= 1'b1;
		walkVa <= va;
		walkAsid <= id;
		walkGlobal <= g;
		walkPa <= pa;
		@(posedge sys_clk);
		walkValid <= 1'b0;
	endtask

	task automatic look(input tlbl_va_t va, input tlbl_asid_t id, input logic eh, input logic el,
			input tlbl_va_t ep);
		@(posedge sys_clk);
		lookValid <= 1'b1;
		lookVa <= va;
		lookAsid <= id;
		@(posedge sys_clk);
		lookValid <= 1'b0;
		#1;
		check("lookHitLocked", {30'h0, lookHit_ff, lookLocked_ff}, {30'h0, eh, el});
		check("lookPa", {12'h0, lookPa_ff}, {12'h0, eh ? ep : 20'h0});
	endtask

	task automatic results;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// -----------------------------------------------------------------
	// test sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		cp(1'b0, 4'ha, 4'h0, 3'h0, 32'h0, 1'b0, 32'h0);
		cp(1'b0, 4'ha, 4'h2, 3'h0, 32'h0, 1'b0, 32'h0009_8aa4);
		cp(1'b0, 4'ha, 4'h2, 3'h1, 32'h0, 1'b0, 32'h44e0_48e0);
		check("primaryRemap", primaryRegionRemap_ff, 32'h0009_8aa4);
		check("normalRemap", normalMemoryRemap_ff, 32'h44e0_48e0);
		cur = 32'h0;
		// every privilege, security and access-bit combination, random data
		for (int i = 0; i < 8; i++) begin
			d = rnd;
			rnd = lfsrNext(rnd);
			priv = i[0];
			nsec = i[1];
			nsAcc = i[2];
			ok = i[0] && (!i[1] || i[2]);
			cp(1'b1, 4'ha, 4'h0, 3'h0, d, !ok, 32'h0);
			if (ok) begin
				cur = lockView(d);
			end
			cp(1'b0, 4'ha, 4'h0, 3'h0, 32'h0, !ok, ok ? cur : 32'h0);
			priv = 1'b1;
			nsec = 1'b0;
			cp(1'b0, 4'ha, 4'h0, 3'h0, 32'h0, 1'b0, cur);
		end
		op1 = 3'h1;
		cp(1'b0, 4'ha, 4'h0, 3'h0, 32'h0, 1'b1, 32'h0);
		op1 = 3'h0;
		cp(1'b0, 4'h8, 4'h3, 3'h0, 32'h0, 1'b1, 32'h0);
		cp(1'b1, 4'h8, 4'h5, 3'h4, 32'h0, 1'b1, 32'h0);
		cp(1'b0, 4'h9, 4'h0, 3'h0, 32'h0, 1'b1, 32'h0);
		d = rnd;
		rnd = lfsrNext(rnd);
		cp(1'b1, 4'ha, 4'h2, 3'h0, d, 1'b0, 32'h0);
		cp(1'b1, 4'ha, 4'h2, 3'h1, ~d, 1'b0, 32'h0);
		check("primaryRemap", primaryRegionRemap_ff, d);
		check("normalRemap", normalMemoryRemap_ff, ~d);
		// fill all four lockdown slots; slot 3 is global so any identifier hits it
		for (int s = 0; s < 4; s++) begin
			lockVa[s] = rnd[19:0];
			lockPa[s] = rnd[31:12];
			rnd = lfsrNext(rnd);
			cp(1'b1, 4'ha, 4'h0, 3'h0, {2'b00, 2'(s), 27'h0, 1'b1}, 1'b0, 32'h0);
			walk(lockVa[s], 8'(s), s == 3, lockPa[s]);
		end
		for (int s = 0; s < 4; s++) begin
			look(lockVa[s], (s == 3) ? 8'h5a : 8'(s), 1'b1, 1'b1, lockPa[s]);
		end
		baseVa = rnd[19:0];
		paC = rnd[31:12];
		rnd = lfsrNext(rnd);
		cp(1'b1, 4'ha, 4'h0, 3'h0, 32'hffff_fffe, 1'b0, 32'h0);
		cp(1'b0, 4'ha, 4'h0, 3'h0, 32'h0, 1'b0, lockView(32'hffff_fffe));
		walk(baseVa, 8'h09, 1'b0, paC);
		look(baseVa, 8'h09, 1'b1, 1'b0, paC);
		look(lockVa[1], 8'h01, 1'b1, 1'b1, lockPa[1]);
		// a fifth locked refill reuses slot 0 and pushes its old entry out
		cp(1'b1, 4'ha, 4'h0, 3'h0, 32'h0000_0001, 1'b0, 32'h0);
		walk(baseVa ^ 20'h2, 8'h09, 1'b0, paC);
		look(lockVa[0], 8'h00, 1'b0, 1'b0, 20'h0);
		look(baseVa ^ 20'h2, 8'h09, 1'b1, 1'b1, paC);
		// every invalidate kind, shared then local; a: locked match, b: locked other, c: unlocked
		for (int k = 0; k < 8; k++) begin
			baseVa = rnd[19:0];
			paA = rnd[31:12];
			rnd = lfsrNext(rnd);
			paB = rnd[19:0];
			paC = rnd[31:12];
			rnd = lfsrNext(rnd);
			secondary_register_number = (k < 4) ? 4'h3 : 4'(5 + k % 3);
			kind = k % 4;
			cp(1'b1, 4'ha, 4'h0, 3'h0, 32'h0000_0001, 1'b0, 32'h0);
			walk(baseVa, 8'h01, 1'b0, paA);
			cp(1'b1, 4'ha, 4'h0, 3'h0, 32'h1000_0001, 1'b0, 32'h0);
			walk(baseVa ^ 20'h1, 8'h02, 1'b0, paB);
			cp(1'b1, 4'ha, 4'h0, 3'h0, 32'h0, 1'b0, 32'h0);
			walk(baseVa, 8'h03, 1'b0, paC);
			cp(1'b1, 4'h8, secondary_register_number, 3'(kind), {baseVa, 12'h001}, 1'b0, 32'h0);
			check("broadcast", {31'h0, invBroadcast_ff}, {31'h0, k < 4});
			look(baseVa, 8'h01, kind == 0 || kind == 3, kind == 0 || kind == 3, paA);
			look(baseVa ^ 20'h1, 8'h02, 1'b1, 1'b1, paB);
			look(baseVa, 8'h03, kind == 1 || kind == 2, 1'b0, paC);
		end
		// a reset in mid-run must restore every register; only the entry at lockVa[1] is probed after it
		@(posedge sys_clk);
		rst <= 1'b1;
		@(posedge sys_clk);
		rst <= 1'b0;
		cp(1'b0, 4'ha, 4'h0, 3'h0, 32'h0, 1'b0, 32'h0);
		check("primaryRemap", primaryRegionRemap_ff, 32'h0009_8aa4);
		check("normalRemap", normalMemoryRemap_ff, 32'h44e0_48e0);
		look(lockVa[1], 8'h01, 1'b0, 1'b0, 20'h0);
		results();
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		error_cnt++;
		results();
	end
endmodule // tlbl_lockdown_ctrl_tb
`default_nettype wire
